/* File: src/pioc_core.sv */
// Behaviour
// - Signed gear numerator, default 1000, scales pulses.
// - Divide by positive gear denominator, default 1000.
// - Format 0 CW/CCW, 1 pulse-dir, 2 quadrature.
// - Pulse noise filter strength 0-255, default 3.
// - Compare pulses per ms against limit 600.
// - Target reached after condition held window ms.
// - Enable input loads control word, default 2F.
// - Capture encoder link state during initialisation.
// - Glitch filter 3-bit select, default 4.
// - Read-only encoder alarm word, zero at reset.
// - Encoder command: clear, read, clear with multiturn.
// - Jog velocity default 30, never saved.
// - Input polarity mask, 1 open, resets ones.
// - Output polarity mask, 1 open, resets ones.
`include "pioc_regs.svh"

module pioc_core #(
  parameter int CYC_PER_MS = `PIOC_CYC_PER_MS,
  parameter int ENABLE_BIT = 0
) (
  // Clock, reset and clock enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Parameter access port
  input wire pioc_pkg::pioc_req_t req,
  output pioc_pkg::pioc_rsp_t rsp,
  // Command pulse pins: line a is CW, pulse or A; line b is CCW, direction or B
  input wire logic pulse_a,
  input wire logic pulse_b,
  output logic signed [31:0] position_count,
  output logic rate_fault,
  // Digital inputs and outputs
  input wire logic [15:0] din_raw,
  output logic [15:0] din_active,
  input wire logic [15:0] dout_func,
  output logic [15:0] dout_pin,
  // Drive state
  input wire logic target_cond,
  output logic target_reached,
  output pioc_pkg::pioc_word_t drive_ctrl_word,
  output logic [15:0] jog_velocity,
  // Encoder side
  input wire logic enc_init,
  input wire logic [15:0] enc_state_in,
  input wire pioc_pkg::pioc_word_t enc_alarm_in,
  output logic enc_cmd_valid,
  output pioc_pkg::pioc_enc_cmd_t enc_cmd
);
  import pioc_pkg::*;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [15:0] gear_num_reg;
  logic [15:0] gear_den_reg;
  logic [7:0] format_reg;
  logic [15:0] noise_reg;
  logic [15:0] rate_lim_reg;
  logic [15:0] settle_reg;
  logic [15:0] en_ctrlw_reg;
  logic [31:0] speed_reg [4];
  logic [15:0] link_reg;
  logic [7:0] glitch_reg;
  logic [15:0] alarm_reg;
  logic [7:0] enc_cmd_reg;
  logic [15:0] jog_reg;
  logic [15:0] in_pol_reg;
  logic [15:0] out_pol_reg;
  logic fault_reg;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire hit_num = req.addr == `PIOC_ADDR_GEAR_NUM;
  wire hit_den = req.addr == `PIOC_ADDR_GEAR_DEN;
  wire hit_fmt = req.addr == `PIOC_ADDR_FORMAT;
  wire hit_noise = req.addr == `PIOC_ADDR_NOISE;
  wire hit_rate = req.addr == `PIOC_ADDR_RATE_LIM;
  wire hit_settle = req.addr == `PIOC_ADDR_SETTLE;
  wire hit_ctrlw = req.addr == `PIOC_ADDR_EN_CTRLW;
  wire hit_link = req.addr == `PIOC_ADDR_LINK;
  wire hit_glitch = req.addr == `PIOC_ADDR_GLITCH;
  wire hit_alarm = req.addr == `PIOC_ADDR_ALARM;
  wire hit_enc = req.addr == `PIOC_ADDR_ENC_CMD;
  wire hit_jog = req.addr == `PIOC_ADDR_JOG;
  wire hit_ipol = req.addr == `PIOC_ADDR_IN_POL;
  wire hit_opol = req.addr == `PIOC_ADDR_OUT_POL;
  wire hit_fault = req.addr == `PIOC_ADDR_FAULT;
  wire [3:0] hit_speed;
  assign hit_speed[0] = req.addr == `PIOC_ADDR_SPEED4;
  assign hit_speed[1] = req.addr == `PIOC_ADDR_SPEED5;
  assign hit_speed[2] = req.addr == `PIOC_ADDR_SPEED6;
  assign hit_speed[3] = req.addr == `PIOC_ADDR_SPEED7;
  wire hit_rw = hit_num | hit_den | hit_fmt | hit_noise | hit_rate | hit_settle | hit_ctrlw
    | hit_glitch | hit_enc | hit_jog | hit_ipol | hit_opol | hit_fault | (|hit_speed);
  wire hit_any = hit_rw | hit_link | hit_alarm;

  // Out-of-range values are refused so the datapath never sees a divide by zero.
  wire den_ok = req.wdata[15:0] != 16'h0000 && req.wdata[15:0] <= `PIOC_MAX_GEAR_DEN;
  wire fmt_ok = req.wdata[7:0] <= `PIOC_MAX_FORMAT;
  wire noise_ok = req.wdata[15:0] <= `PIOC_MAX_NOISE;
  wire rate_ok = req.wdata[15:0] <= `PIOC_MAX_RATE_LIM;
  wire glitch_ok = req.wdata[7:0] <= `PIOC_MAX_GLITCH;
  wire cmd_ok = req.wdata[7:0] <= 8'h03;
  wire wr_bad = (hit_den & ~den_ok) | (hit_fmt & ~fmt_ok) | (hit_noise & ~noise_ok)
    | (hit_rate & ~rate_ok) | (hit_glitch & ~glitch_ok) | (hit_enc & ~cmd_ok);
  wire wr_ok = req.wr & hit_rw & ~wr_bad;
  wire wr_err = req.wr & (~hit_rw | wr_bad);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_num) rd_mux = {16'h0000, gear_num_reg};
    if (hit_den) rd_mux = {16'h0000, gear_den_reg};
    if (hit_fmt) rd_mux = {24'h00_0000, format_reg};
    if (hit_noise) rd_mux = {16'h0000, noise_reg};
    if (hit_rate) rd_mux = {16'h0000, rate_lim_reg};
    if (hit_settle) rd_mux = {16'h0000, settle_reg};
    if (hit_ctrlw) rd_mux = {16'h0000, en_ctrlw_reg};
    if (hit_link) rd_mux = {16'h0000, link_reg};
    if (hit_glitch) rd_mux = {24'h00_0000, glitch_reg};
    if (hit_alarm) rd_mux = {16'h0000, alarm_reg};
    if (hit_enc) rd_mux = {24'h00_0000, enc_cmd_reg};
    if (hit_jog) rd_mux = {16'h0000, jog_reg};
    if (hit_ipol) rd_mux = {16'h0000, in_pol_reg};
    if (hit_opol) rd_mux = {16'h0000, out_pol_reg};
    if (hit_fault) rd_mux = {31'h0000_0000, fault_reg};
    for (int i = 0; i < 4; i++) begin
      if (hit_speed[i]) rd_mux = speed_reg[i];
    end
  end

  // --------------------------------------------------------------------------
  // Parameter writes and read answers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gear_num_reg <= `PIOC_RST_GEAR_NUM;
      gear_den_reg <= `PIOC_RST_GEAR_DEN;
      format_reg <= `PIOC_RST_FORMAT;
      noise_reg <= `PIOC_RST_NOISE;
      rate_lim_reg <= `PIOC_RST_RATE_LIM;
      settle_reg <= `PIOC_RST_SETTLE;
      en_ctrlw_reg <= `PIOC_RST_EN_CTRLW;
      glitch_reg <= `PIOC_RST_GLITCH;
      enc_cmd_reg <= 8'h00;
      jog_reg <= `PIOC_RST_JOG;
      in_pol_reg <= `PIOC_RST_POL;
      out_pol_reg <= `PIOC_RST_POL;
      rsp <= '0;
    end else if (ce) begin
      if (wr_ok && hit_num) gear_num_reg <= req.wdata[15:0];
      if (wr_ok && hit_den) gear_den_reg <= req.wdata[15:0];
      if (wr_ok && hit_fmt) format_reg <= req.wdata[7:0];
      if (wr_ok && hit_noise) noise_reg <= req.wdata[15:0];
      if (wr_ok && hit_rate) rate_lim_reg <= req.wdata[15:0];
      if (wr_ok && hit_settle) settle_reg <= req.wdata[15:0];
      if (wr_ok && hit_ctrlw) en_ctrlw_reg <= req.wdata[15:0];
      if (wr_ok && hit_glitch) glitch_reg <= req.wdata[7:0];
      if (wr_ok && hit_enc) enc_cmd_reg <= req.wdata[7:0];
      if (wr_ok && hit_jog) jog_reg <= req.wdata[15:0];
      if (wr_ok && hit_ipol) in_pol_reg <= req.wdata[15:0];
      if (wr_ok && hit_opol) out_pol_reg <= req.wdata[15:0];
      rsp.valid <= req.rd | req.wr;
      rsp.err <= (req.rd & ~hit_any) | wr_err;
      rsp.rdata <= req.rd ? rd_mux : 32'h0000_0000;
      // Jog speed and the live status words are kept out of a parameter save.
      rsp.savable <= req.rd & hit_any & ~hit_jog & ~hit_enc & ~hit_link & ~hit_alarm
        & ~hit_fault;
    end
  end

  generate
    for (genvar s = 0; s < 4; s++) begin : g_speed
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          speed_reg[s] <= 32'h0000_0000;
        end else if (ce && wr_ok && hit_speed[s]) begin
          speed_reg[s] <= req.wdata;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Millisecond tick
  // --------------------------------------------------------------------------
  logic [16:0] ms_cnt_reg;
  wire ms_tick = ms_cnt_reg == 17'(CYC_PER_MS - 1);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ms_cnt_reg <= 17'h0_0000;
    end else if (ce) begin
      ms_cnt_reg <= ms_tick ? 17'h0_0000 : ms_cnt_reg + 17'h0_0001;
    end
  end

  // --------------------------------------------------------------------------
  // Glitch filter and noise filter, one per pulse line
  // --------------------------------------------------------------------------
  localparam logic [16:0] GL0 = 17'((`PIOC_GLITCH0_NS * `PIOC_CLK_MHZ + 999) / 1000);
  localparam logic [16:0] GL1 = 17'((`PIOC_GLITCH1_NS * `PIOC_CLK_MHZ + 999) / 1000);
  localparam logic [16:0] GL2 = 17'((`PIOC_GLITCH2_NS * `PIOC_CLK_MHZ + 999) / 1000);
  localparam logic [16:0] GL3 = 17'((`PIOC_GLITCH3_NS * `PIOC_CLK_MHZ + 999) / 1000);
  localparam logic [16:0] GL4 = 17'(`PIOC_GLITCH4_US * CYC_PER_MS / 1000);
  localparam logic [16:0] GL5 = 17'(`PIOC_GLITCH5_US * CYC_PER_MS / 1000);
  localparam logic [16:0] GL6 = 17'(`PIOC_GLITCH6_US * CYC_PER_MS / 1000);
  localparam logic [16:0] GL7 = 17'(`PIOC_GLITCH7_US * CYC_PER_MS / 1000);

  logic [16:0] glitch_len;
  always_comb begin
    unique case (glitch_reg[2:0])
      3'h0: glitch_len = GL0;
      3'h1: glitch_len = GL1;
      3'h2: glitch_len = GL2;
      3'h3: glitch_len = GL3;
      3'h4: glitch_len = GL4;
      3'h5: glitch_len = GL5;
      3'h6: glitch_len = GL6;
      3'h7: glitch_len = GL7;
    endcase
  end

  wire [1:0] line_in = {pulse_b, pulse_a};
  logic [1:0] glitch_out;
  logic [1:0] clean;
  generate
    for (genvar c = 0; c < 2; c++) begin : g_line
      logic [16:0] gcnt_reg;
      logic [7:0] ncnt_reg;
      logic gout_reg;
      logic nout_reg;
      // A change passes only once it has been stable for the selected width.
      wire g_diff = line_in[c] != gout_reg;
      wire g_done = gcnt_reg + 17'h0_0001 >= glitch_len;
      wire n_diff = gout_reg != nout_reg;
      wire n_done = {8'h00, ncnt_reg} >= noise_reg;
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          gcnt_reg <= 17'h0_0000;
          gout_reg <= 1'b0;
        end else if (ce) begin
          gcnt_reg <= (g_diff && !g_done) ? gcnt_reg + 17'h0_0001 : 17'h0_0000;
          if (g_diff && g_done) gout_reg <= line_in[c];
        end
      end
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          ncnt_reg <= 8'h00;
          nout_reg <= 1'b0;
        end else if (ce) begin
          ncnt_reg <= (n_diff && !n_done) ? ncnt_reg + 8'h01 : 8'h00;
          if (n_diff && n_done) nout_reg <= gout_reg;
        end
      end
      assign glitch_out[c] = gout_reg;
      assign clean[c] = nout_reg;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Pulse decode
  // --------------------------------------------------------------------------
  logic [1:0] prev_reg;
  wire rise_a = clean[0] & ~prev_reg[0];
  wire rise_b = clean[1] & ~prev_reg[1];
  wire [3:0] quad = {prev_reg[1], prev_reg[0], clean[1], clean[0]};
  wire quad_up = quad == 4'b0001 || quad == 4'b0111 || quad == 4'b1110 || quad == 4'b1000;
  wire quad_dn = quad == 4'b0010 || quad == 4'b1011 || quad == 4'b1101 || quad == 4'b0100;
  logic step_up;
  logic step_dn;
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    unique case (pioc_format_t'(format_reg[1:0]))
      PIOC_FMT_CW_CCW: begin
        step_up = rise_a & ~rise_b;
        step_dn = rise_b & ~rise_a;
      end
      PIOC_FMT_PULSE_DIR: begin
        step_up = rise_a & ~clean[1];
        step_dn = rise_a & clean[1];
      end
      PIOC_FMT_QUAD: begin
        step_up = quad_up;
        step_dn = quad_dn;
      end
      default: begin
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Electronic gear: remainder carried so no count is lost over time
  // --------------------------------------------------------------------------
  logic signed [31:0] rem_reg;
  wire signed [31:0] num_s = 32'(signed'(gear_num_reg));
  wire signed [31:0] den_s = {16'h0000, gear_den_reg};
  wire signed [31:0] gear_sum = rem_reg + (step_up ? num_s : -num_s);
  wire signed [31:0] gear_quo = gear_sum / den_s;
  wire signed [31:0] gear_rem = gear_sum % den_s;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_reg <= 2'b00;
      rem_reg <= 32'sh0;
      position_count <= 32'sh0;
    end else if (ce) begin
      prev_reg <= clean;
      if (step_up || step_dn) begin
        rem_reg <= gear_rem;
        position_count <= position_count + gear_quo;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pulse rate check
  // --------------------------------------------------------------------------
  logic [15:0] rate_cnt_reg;
  wire rate_over = ms_tick && rate_cnt_reg > rate_lim_reg;
  wire fault_clr = ce && wr_ok && hit_fault && req.wdata[0];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rate_cnt_reg <= 16'h0000;
      fault_reg <= 1'b0;
      rate_fault <= 1'b0;
    end else if (ce) begin
      if (ms_tick) rate_cnt_reg <= 16'h0000;
      else if ((step_up || step_dn) && rate_cnt_reg != 16'hffff) rate_cnt_reg <= rate_cnt_reg + 16'h0001;
      // A new overrun in the clearing cycle keeps the flag set.
      if (rate_over) fault_reg <= 1'b1;
      else if (fault_clr) fault_reg <= 1'b0;
      rate_fault <= rate_over | (fault_reg & ~fault_clr);
    end
  end

  // --------------------------------------------------------------------------
  // Target reached timer
  // --------------------------------------------------------------------------
  logic [15:0] settle_cnt_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      settle_cnt_reg <= 16'h0000;
      target_reached <= 1'b0;
    end else if (ce) begin
      if (!target_cond) settle_cnt_reg <= 16'h0000;
      else if (ms_tick && settle_cnt_reg != 16'hffff) settle_cnt_reg <= settle_cnt_reg + 16'h0001;
      target_reached <= target_cond && settle_cnt_reg >= settle_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Digital I/O polarity and enable injection
  // --------------------------------------------------------------------------
  wire [15:0] din_now = ~(din_raw ^ in_pol_reg);
  logic en_prev_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      din_active <= 16'h0000;
      dout_pin <= 16'h0000;
      en_prev_reg <= 1'b0;
      drive_ctrl_word <= '0;
      jog_velocity <= `PIOC_RST_JOG;
    end else if (ce) begin
      din_active <= din_now;
      dout_pin <= ~(dout_func ^ out_pol_reg);
      en_prev_reg <= din_now[ENABLE_BIT];
      drive_ctrl_word.valid <= din_now[ENABLE_BIT] & ~en_prev_reg;
      if (din_now[ENABLE_BIT] && !en_prev_reg) drive_ctrl_word.value <= en_ctrlw_reg;
      jog_velocity <= jog_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Encoder state, alarm and maintenance commands
  // --------------------------------------------------------------------------
  wire cmd_wr = ce && wr_ok && hit_enc;
  wire alarm_clr = cmd_wr && (req.wdata[1:0] == 2'h1 || req.wdata[1:0] == 2'h3);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      link_reg <= 16'h0000;
      alarm_reg <= 16'h0000;
      enc_cmd_valid <= 1'b0;
      enc_cmd <= PIOC_ENC_NONE;
    end else if (ce) begin
      if (enc_init) link_reg <= enc_state_in;
      // A fresh alarm report wins over a clear in the same cycle.
      if (enc_alarm_in.valid) alarm_reg <= enc_alarm_in.value;
      else if (alarm_clr) alarm_reg <= 16'h0000;
      enc_cmd_valid <= cmd_wr && req.wdata[1:0] != 2'h0;
      if (cmd_wr) enc_cmd <= pioc_enc_cmd_t'(req.wdata[1:0]);
    end
  end

endmodule

/* File: src/pioc_pkg.sv */
package pioc_pkg;

  typedef enum logic [1:0] {
    PIOC_FMT_CW_CCW = 2'b00,
    PIOC_FMT_PULSE_DIR = 2'b01,
    PIOC_FMT_QUAD = 2'b10
  } pioc_format_t;

  typedef enum logic [1:0] {
    PIOC_ENC_NONE = 2'b00,
    PIOC_ENC_CLEAR = 2'b01,
    PIOC_ENC_READ = 2'b10,
    PIOC_ENC_CLEAR_MT = 2'b11
  } pioc_enc_cmd_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pioc_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic savable;
    logic [31:0] rdata;
  } pioc_rsp_t;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } pioc_word_t;

endpackage

/* File: src/pioc_regs.svh */
`ifndef PIOC_REGS_SVH
`define PIOC_REGS_SVH

// ----------------------------------------------------------------------------
// Parameter addresses: index, sub-index and size code
// ----------------------------------------------------------------------------
`define PIOC_ADDR_GEAR_NUM 32'h25080110
`define PIOC_ADDR_GEAR_DEN 32'h25080210
`define PIOC_ADDR_FORMAT 32'h25080308
`define PIOC_ADDR_NOISE 32'h25080610
`define PIOC_ADDR_RATE_LIM 32'h25080810
`define PIOC_ADDR_SETTLE 32'h25080910
`define PIOC_ADDR_EN_CTRLW 32'h20200f10
`define PIOC_ADDR_SPEED4 32'h20201820
`define PIOC_ADDR_SPEED5 32'h20201920
`define PIOC_ADDR_SPEED6 32'h20201a20
`define PIOC_ADDR_SPEED7 32'h20201b20
`define PIOC_ADDR_LINK 32'h30450010
`define PIOC_ADDR_GLITCH 32'h30460008
`define PIOC_ADDR_ALARM 32'h30510110
`define PIOC_ADDR_ENC_CMD 32'h26900008
`define PIOC_ADDR_JOG 32'h2ff02310
`define PIOC_ADDR_IN_POL 32'h20100110
`define PIOC_ADDR_OUT_POL 32'h20100d10
`define PIOC_ADDR_FAULT 32'h25080a08

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define PIOC_RST_GEAR_NUM 16'h03e8
`define PIOC_RST_GEAR_DEN 16'h03e8
`define PIOC_MAX_GEAR_DEN 16'h7fff
`define PIOC_RST_FORMAT 8'h01
`define PIOC_MAX_FORMAT 8'h02
`define PIOC_RST_NOISE 16'h0003
`define PIOC_MAX_NOISE 16'h00ff
`define PIOC_RST_RATE_LIM 16'h0258
`define PIOC_MAX_RATE_LIM 16'h0bb8
`define PIOC_RST_SETTLE 16'h000a
`define PIOC_RST_EN_CTRLW 16'h002f
`define PIOC_RST_JOG 16'h001e
`define PIOC_RST_GLITCH 8'h04
`define PIOC_MAX_GLITCH 8'h07
`define PIOC_RST_POL 16'hffff

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PIOC_CLK_MHZ 20
`define PIOC_CYC_PER_MS 20000
`define PIOC_GLITCH0_NS 125
`define PIOC_GLITCH1_NS 156
`define PIOC_GLITCH2_NS 250
`define PIOC_GLITCH3_NS 313
`define PIOC_GLITCH4_US 1000
`define PIOC_GLITCH5_US 1500
`define PIOC_GLITCH6_US 2000
`define PIOC_GLITCH7_US 4000

`endif

/* File: test/pioc_asserts.sv */
`include "pioc_regs.svh"
module pioc_asserts (
  // Watched ports of the core
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire pioc_pkg::pioc_req_t req,
  input wire pioc_pkg::pioc_rsp_t rsp,
  input wire logic [15:0] din_raw,
  input wire logic [15:0] din_active,
  input wire logic target_cond,
  input wire logic target_reached,
  input wire pioc_pkg::pioc_word_t drive_ctrl_word,
  input wire logic enc_cmd_valid,
  input wire pioc_pkg::pioc_enc_cmd_t enc_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  import pioc_pkg::*;
  // The mask shadow lets the polarity check follow software writes.
  logic [15:0] mask_reg;
  logic [1:0] age_reg;
  wire wr_en = ce && req.wr;
  wire cmd_ok = wr_en && req.addr == `PIOC_ADDR_ENC_CMD && req.wdata[7:0] inside {1, 2, 3};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= 16'hffff;
      age_reg <= 2'h0;
    end else begin
      if (wr_en && req.addr == `PIOC_ADDR_IN_POL) mask_reg <= req.wdata[15:0];
      if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_cmd_take;
    cmd_ok;
  endsequence
  sequence s_cmd_pulse;
    enc_cmd_valid && enc_cmd == pioc_enc_cmd_t'($past(req.wdata[1:0]));
  endsequence
  a_den_refused: assert property (wr_en && req.addr == `PIOC_ADDR_GEAR_DEN &&
    (req.wdata == 0 || req.wdata > 32'h7fff) |=> rsp.valid && rsp.err)
    else $error("bad gear denominator accepted");
  a_fmt_refused: assert property (wr_en && req.addr == `PIOC_ADDR_FORMAT &&
    req.wdata > 32'h2 |=> rsp.valid && rsp.err) else $error("bad pulse format accepted");
  a_rate_refused: assert property (wr_en && req.addr == `PIOC_ADDR_RATE_LIM &&
    req.wdata > 32'hbb8 |=> rsp.err) else $error("bad rate limit accepted");
  a_jog_unsaved: assert property (ce && req.rd && !req.wr &&
    req.addr == `PIOC_ADDR_JOG |=> rsp.valid && !rsp.savable) else $error("jog marked savable");
  a_in_polarity: assert property (age_reg == 2'h3 && $past(ce) |->
    din_active == ~($past(din_raw) ^ $past(mask_reg))) else $error("input polarity wrong");
  a_cmd_pulse: assert property (s_cmd_take |=> s_cmd_pulse)
    else $error("encoder command not issued");
  a_cmd_quiet: assert property (!cmd_ok |=> !enc_cmd_valid)
    else $error("spurious encoder command");
  a_target_drop: assert property (!target_cond |=> !target_reached)
    else $error("target reached without condition");
  a_enable_load: assert property ($rose(din_active[0]) |-> drive_ctrl_word.valid)
    else $error("enable word not loaded");
endmodule

/* File: test/pioc_pulse_src.sv */
module pioc_pulse_src (
  // Command pulse lines
  input wire logic core_clk,
  output logic pulse_a,
  output logic pulse_b
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
  end
  // Each level is held long enough to clear the shortest filter setting.
  task automatic hold(input logic a, input logic b);
    pulse_a = a;
    pulse_b = b;
    repeat (8) @(posedge core_clk);
    #2;
  endtask
  task automatic send(input int fmt, input int n, input logic neg);
    for (int k = 0; k < n; k++) begin
      case (fmt)
        0: begin
          hold(!neg, neg);
          hold(1'b0, 1'b0);
        end
        1: begin
          hold(1'b0, neg);
          hold(1'b1, neg);
        end
        default: begin
          hold(!neg, neg);
          hold(1'b1, 1'b1);
          hold(neg, !neg);
          hold(1'b0, 1'b0);
        end
      endcase
    end
    hold(1'b0, 1'b0);
  endtask
endmodule

/* File: test/tb_pulse_input_io_config.sv */
`include "pioc_regs.svh"
module tb_pulse_input_io_config;
  timeunit 1ns;
  timeprecision 1ns;
  import pioc_pkg::*;
  logic core_clk, rstn, ce, pulse_a, pulse_b, rate_fault, target_cond, target_reached;
  logic enc_init, enc_cmd_valid, ev;
  logic signed [31:0] position_count, p0;
  logic [15:0] din_raw, din_active, dout_func, dout_pin, jog_velocity, enc_state_in;
  pioc_req_t req;
  pioc_rsp_t rsp, r;
  pioc_word_t drive_ctrl_word, enc_alarm_in;
  pioc_enc_cmd_t enc_cmd, ec;
  int bad_count = 0, comparisons = 0, i;
  logic [31:0] ra [15] = '{`PIOC_ADDR_GEAR_NUM, `PIOC_ADDR_GEAR_DEN, `PIOC_ADDR_FORMAT,
    `PIOC_ADDR_NOISE, `PIOC_ADDR_RATE_LIM, `PIOC_ADDR_SETTLE, `PIOC_ADDR_EN_CTRLW,
    `PIOC_ADDR_LINK, `PIOC_ADDR_GLITCH, `PIOC_ADDR_ALARM, `PIOC_ADDR_ENC_CMD,
    `PIOC_ADDR_JOG, `PIOC_ADDR_IN_POL, `PIOC_ADDR_OUT_POL, `PIOC_ADDR_SPEED4};
  logic [31:0] rv [15] = '{32'h3e8, 32'h3e8, 32'h1, 32'h3, 32'h258, 32'ha, 32'h2f,
    32'h0, 32'h4, 32'h0, 32'h0, 32'h1e, 32'hffff, 32'hffff, 32'h0};
  logic [31:0] ba [9] = '{`PIOC_ADDR_GEAR_DEN, `PIOC_ADDR_GEAR_DEN, `PIOC_ADDR_FORMAT,
    `PIOC_ADDR_NOISE, `PIOC_ADDR_RATE_LIM, `PIOC_ADDR_GLITCH, `PIOC_ADDR_ENC_CMD,
    `PIOC_ADDR_LINK, 32'h25080510};
  logic [31:0] bv [9] = '{32'h0, 32'h8000, 32'h3, 32'h100, 32'hbb9, 32'h8, 32'h4, 32'h1, 32'h1};

  pioc_core #(.CYC_PER_MS(20)) u_dut (.core_clk, .rstn, .ce, .req, .rsp, .pulse_a, .pulse_b,
    .position_count, .rate_fault, .din_raw, .din_active, .dout_func, .dout_pin, .target_cond,
    .target_reached, .drive_ctrl_word, .jog_velocity, .enc_init, .enc_state_in, .enc_alarm_in,
    .enc_cmd_valid, .enc_cmd);
  pioc_pulse_src u_src (.core_clk, .pulse_a, .pulse_b);

  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    req = '{w, !w, a, d};
    @(posedge core_clk);
    #2;
    req = '0;
    r = rsp;
    ec = enc_cmd;
    ev = enc_cmd_valid;
    @(posedge core_clk);
    #2;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    tick(20000);
    bad_count++;
    wrap_up();
  end
  // ----------------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------------
  initial begin
    {rstn, target_cond, enc_init, din_raw, dout_func, enc_state_in, req, enc_alarm_in} = '0;
    ce = 1'b1;
    tick(5);
    rstn = 1'b1;
    chk("jog_port", 32'h1e, jog_velocity);
    for (i = 0; i < 15; i++) begin
      acc(0, ra[i], 0);
      chk("reset_value", rv[i], r.rdata);
    end
    for (i = 0; i < 9; i++) begin
      acc(1, ba[i], bv[i]);
      chk("refused", 1, r.err);
    end
    acc(0, 32'h25080510, 0);
    chk("unmapped", 33'h100000000, {r.err, r.rdata});
    acc(0, `PIOC_ADDR_GEAR_DEN, 0);
    chk("den_kept", 32'h3e8, r.rdata);
    chk("den_save", 1, r.savable);
    acc(1, `PIOC_ADDR_GLITCH, 7);
    acc(0, `PIOC_ADDR_GLITCH, 0);
    chk("glitch_max", 7, r.rdata);
    acc(1, `PIOC_ADDR_NOISE, 32'hff);
    acc(0, `PIOC_ADDR_NOISE, 0);
    chk("noise_max", 32'hff, r.rdata);
    acc(1, `PIOC_ADDR_GLITCH, 0);
    acc(1, `PIOC_ADDR_NOISE, 0);
    for (i = 0; i < 3; i++) begin
      acc(1, `PIOC_ADDR_FORMAT, i);
      p0 = position_count;
      u_src.send(i, 3, 1'b0);
      u_src.send(i, 1, 1'b1);
      tick(10);
      chk("position", p0 + (i == 2 ? 8 : 2), position_count);
    end
    acc(1, `PIOC_ADDR_FORMAT, 1);
    acc(1, `PIOC_ADDR_GEAR_NUM, 32'h7d0);
    p0 = position_count;
    u_src.send(1, 3, 1'b0);
    tick(10);
    chk("gear_up", p0 + 6, position_count);
    acc(1, `PIOC_ADDR_GEAR_NUM, 32'hfc18);
    acc(1, `PIOC_ADDR_GEAR_DEN, 32'h7fff);
    acc(1, `PIOC_ADDR_GEAR_DEN, 32'h1f4);
    p0 = position_count;
    u_src.send(1, 1, 1'b0);
    tick(10);
    chk("gear_neg", p0 - 2, position_count);
    chk("no_fault", 0, rate_fault);
    acc(1, `PIOC_ADDR_RATE_LIM, 0);
    u_src.send(1, 4, 1'b0);
    chk("rate_fault", 1, rate_fault);
    tick(60);
    acc(0, `PIOC_ADDR_FAULT, 0);
    chk("fault_bit", 1, r.rdata[0]);
    acc(1, `PIOC_ADDR_FAULT, 1);
    acc(0, `PIOC_ADDR_FAULT, 0);
    chk("fault_clear", 0, r.rdata[0]);
    acc(1, `PIOC_ADDR_SETTLE, 2);
    target_cond = 1'b1;
    tick(15);
    chk("early_reach", 0, target_reached);
    for (i = 0; i < 60 && target_reached !== 1'b1; i++) tick(1);
    chk("reached", 1, target_reached);
    target_cond = 1'b0;
    acc(1, `PIOC_ADDR_EN_CTRLW, 32'h1234);
    din_raw = 16'h0001;
    for (i = 0; i < 5 && drive_ctrl_word.valid !== 1'b1; i++) tick(1);
    chk("ctrl_word", 32'h11234, {drive_ctrl_word.valid, drive_ctrl_word.value});
    acc(1, `PIOC_ADDR_IN_POL, 32'h00f0);
    din_raw = 16'h0ff0;
    tick(2);
    chk("din_active", 16'(~(16'h0ff0 ^ 16'h00f0)), din_active);
    acc(1, `PIOC_ADDR_OUT_POL, 32'h0f0f);
    dout_func = 16'h00ff;
    tick(2);
    chk("dout_pin", 16'(~(16'h00ff ^ 16'h0f0f)), dout_pin);
    {enc_init, enc_state_in} = {1'b1, 16'h5a5a};
    tick(1);
    {enc_init, enc_state_in} = {1'b0, 16'h0001};
    acc(0, `PIOC_ADDR_LINK, 0);
    chk("link_state", 32'h5a5a, r.rdata);
    for (i = 1; i < 4; i++) begin
      enc_alarm_in = '{1'b1, 16'h0123};
      tick(1);
      enc_alarm_in = '0;
      acc(0, `PIOC_ADDR_ALARM, 0);
      chk("alarm", 32'h123, r.rdata);
      acc(1, `PIOC_ADDR_ENC_CMD, i);
      chk("enc_cmd", {1'b1, 2'(i)}, {ev, ec});
      acc(0, `PIOC_ADDR_ALARM, 0);
      chk("alarm_clear", i == 2 ? 32'h123 : 0, r.rdata);
    end
    acc(1, `PIOC_ADDR_ENC_CMD, 0);
    chk("enc_idle", 0, ev);
    acc(1, `PIOC_ADDR_JOG, 32'h64);
    chk("jog_port", 32'h64, jog_velocity);
    acc(0, `PIOC_ADDR_JOG, 0);
    chk("jog_save", 0, r.savable);
    wrap_up();
  end
endmodule

bind pioc_core pioc_asserts u_chk (.core_clk, .rstn, .ce, .req, .rsp, .din_raw, .din_active,
  .target_cond, .target_reached, .drive_ctrl_word, .enc_cmd_valid, .enc_cmd);
